// ### verilog/iasq_regs.vh
`ifndef IASQ_REGS_VH
`define IASQ_REGS_VH

// Register offsets on the plain register port
`define IASQ_ADR_ENA_LO   8'h00
`define IASQ_ADR_ENA_HI   8'h01
`define IASQ_ADR_LAT_LO   8'h02
`define IASQ_ADR_LAT_HI   8'h03
`define IASQ_ADR_SEL      8'h04
`define IASQ_ADR_SP_LO    8'h05
`define IASQ_ADR_SP_HI    8'h06
`define IASQ_ADR_STAT     8'h07

// Field positions
`define IASQ_ENA_IMF_BIT  0
`define IASQ_SEL_L10_BIT  0
`define IASQ_SEL_L15_BIT  1
`define IASQ_SEL_L16_BIT  2
`define IASQ_PSW_IMF_BIT  0
`define IASQ_L10_IDX      9
`define IASQ_L15_IDX      14
`define IASQ_L16_IDX      15

// Latch indices of the non-maskable sources
`define IASQ_IDX_SOFT     0
`define IASQ_IDX_BADOP    1
`define IASQ_IDX_FTRAP    2
`define IASQ_IDX_WDOG     3

// Reset values
`define IASQ_RST_ENA      16'h0000
`define IASQ_RST_LAT      16'h0000
`define IASQ_RST_SEL      3'h0
`define IASQ_RST_SP       16'h00FF

// Timing counts, in machine cycles unless noted
`define IASQ_ACC_CYCLES   8
`define IASQ_RET_CYCLES   4
`define IASQ_MAX_LAT_FC   38
`define IASQ_MC_DIV       4

// Memory map figures
`define IASQ_SOFT_OPCODE  8'hFF
`define IASQ_SFR_END      16'h003F
`define IASQ_DBR_BEGIN    16'h0F80
`define IASQ_DBR_END      16'h0FFF
`define IASQ_RAM_END      16'h023F
`define IASQ_VEC_TOP      16'hFFFE

`endif

// ### verilog/iasq_core.v
`timescale 1ns/10ps
`include "iasq_regs.vh"

// Notes on behaviour
// - Shared level takes only its selected source
// - Unselected shared requests are dropped outright
// - Level 10: 0 serial receive, 1 sync serial
// - Level 15: 0 input three, 1 timer three
// - Level 16: 0 input five, 1 timer five
// - Latch holds until accept, reset or write
// - Acceptance after instruction, eight machine cycles
// - Acceptance clears global mask enable
// - Only accepted source latch is cleared
// - Push status, PC high, PC low; SP-3
// - PC loaded from source vector entry
// - Latch to acceptance within 38 clocks
// - Global enable zero blocks every maskable request
// - Return restores PC, status, enable; SP+3
// - Stacked PC low at SP+1, high SP+2
// - Requests sampled in last instruction cycle
// - Opcode FFH raises top-priority soft trap
// - Missing memory fetch in single-chip mode returns FFH
// - Fetch from RAM/buffer/registers raises trap
// - Bad opcode trap preempts at once
// - Only PC and status saved automatically
// - Reset clears global mask enable
// - Maskable source needs its enable bit
module iasq_core #(
  parameter MC_DIV  = `IASQ_MC_DIV,
  parameter RAM_END = `IASQ_RAM_END,
  parameter VEC_TOP = `IASQ_VEC_TOP
) (
  input  wire        clk_sys_i,
  input  wire        resetn_i,
  input  wire [7:0]  reg_addr_i,
  input  wire [7:0]  reg_wdata_i,
  input  wire        reg_wr_i,
  input  wire        reg_rd_i,
  output reg  [7:0]  reg_rdata_o,
  input  wire [15:4] irq_i,
  input  wire        serial_receive_irq_i,
  input  wire        sync_serial_irq_i,
  input  wire        ext_input_three_irq_i,
  input  wire        timer_three_irq_i,
  input  wire        ext_input_five_irq_i,
  input  wire        timer_five_irq_i,
  input  wire        wdog_irq_i,
  input  wire        instr_last_i,
  input  wire        maskable_return_i,
  input  wire        nonmaskable_return_i,
  input  wire        bad_opcode_i,
  input  wire        fetch_valid_i,
  input  wire [15:0] fetch_addr_i,
  input  wire        single_chip_i,
  input  wire        mem_present_i,
  input  wire [7:0]  mem_rdata_i,
  input  wire [15:0] pc_i,
  input  wire [7:0]  status_word_i,
  output reg         mc_tick_o,
  output reg  [7:0]  fetch_data_o,
  output reg         busy_o,
  output reg         mem_wr_o,
  output reg         mem_rd_o,
  output reg  [15:0] mem_addr_o,
  output reg  [7:0]  mem_wdata_o,
  output reg  [15:0] pc_o,
  output reg         pc_load_o,
  output reg  [7:0]  status_word_o,
  output reg         status_load_o,
  output reg  [15:0] stack_pointer_o,
  output reg         global_mask_enable_o
);

  localparam ST_IDLE = 2'b00;
  localparam ST_ACC  = 2'b01;
  localparam ST_RET  = 2'b10;

  reg  [1:0]  state_r;
  reg  [2:0]  step_r;
  reg  [7:0]  mc_cnt_r;
  reg  [15:4] source_enable_bit_r;
  reg  [15:0] pending_latch_r;
  reg  [15:0] pending_latch_nxt;
  reg         level10_source_pick_r;
  reg         level15_source_pick_r;
  reg         level16_source_pick_r;
  reg  [3:0]  accept_idx_r;
  reg         saved_imf_r;
  reg  [7:0]  tmp_lo_r;
  reg  [7:0]  tmp_hi_r;
  reg  [15:0] set_req;
  reg  [15:0] eligible;
  reg  [4:0]  winner;
  wire        mc_en;
  wire        start_acc;
  wire [15:0] vec_addr;

  // Index of the highest-priority set bit, lowest index first
  function [4:0] pick_first;
    input [15:0] v;
    integer      i;
    begin
      pick_first = 5'h00;
      for (i = 15; i >= 0; i = i - 1) begin
        if (v[i]) begin
          pick_first = {1'b1, i[3:0]};
        end
      end
    end
  endfunction

  // Instruction fetch from an area that holds no code
  function trap_area;
    input [15:0] a;
    input [15:0] ram_end;
    begin
      trap_area = (a <= ram_end) ||
                  ((a >= `IASQ_DBR_BEGIN) && (a <= `IASQ_DBR_END));
    end
  endfunction

  // Machine cycle divider
  assign mc_en = (mc_cnt_r == MC_DIV[7:0] - 8'h01);

  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mc_cnt_r  <= 8'h00;
      mc_tick_o <= 1'b0;
    end else begin
      mc_cnt_r  <= mc_en ? 8'h00 : mc_cnt_r + 8'h01;
      mc_tick_o <= mc_en;
    end
  end

  // Fetch data path seen by the decoder
  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fetch_data_o <= 8'h00;
    end else if (fetch_valid_i) begin
      fetch_data_o <= (single_chip_i && !mem_present_i) ? `IASQ_SOFT_OPCODE : mem_rdata_i;
    end
  end

  // Request sources onto latch set terms
  always @* begin
    set_req = {irq_i, 4'h0};
    set_req[`IASQ_L10_IDX] = level10_source_pick_r ? sync_serial_irq_i : serial_receive_irq_i;
    set_req[`IASQ_L15_IDX] = level15_source_pick_r ? timer_three_irq_i : ext_input_three_irq_i;
    set_req[`IASQ_L16_IDX] = level16_source_pick_r ? timer_five_irq_i : ext_input_five_irq_i;
    // Missing memory in single-chip mode also decodes as FFH
    set_req[`IASQ_IDX_SOFT] = fetch_valid_i && !trap_area(fetch_addr_i, RAM_END[15:0]) &&
                              ((single_chip_i && !mem_present_i) ||
                               (mem_rdata_i == `IASQ_SOFT_OPCODE));
    set_req[`IASQ_IDX_BADOP] = bad_opcode_i;
    set_req[`IASQ_IDX_FTRAP] = fetch_valid_i && trap_area(fetch_addr_i, RAM_END[15:0]);
    set_req[`IASQ_IDX_WDOG] = wdog_irq_i;
  end

  // Eligible requests and the winning source
  always @* begin
    eligible = pending_latch_r & {source_enable_bit_r &
               {12{global_mask_enable_o}}, 4'hF};
    winner = pick_first(eligible);
  end

  assign start_acc = mc_en && (state_r == ST_IDLE) && winner[4] &&
                     (instr_last_i || (|pending_latch_r[2:0]));

  assign vec_addr = VEC_TOP[15:0] - {11'h000, accept_idx_r, 1'b0};

  // Pending latches: hardware set wins over clear
  always @* begin
    pending_latch_nxt = pending_latch_r;
    if (reg_wr_i && reg_addr_i == `IASQ_ADR_LAT_LO) begin
      pending_latch_nxt[7:0] = pending_latch_r[7:0] & reg_wdata_i;
    end
    if (reg_wr_i && reg_addr_i == `IASQ_ADR_LAT_HI) begin
      pending_latch_nxt[15:8] = pending_latch_r[15:8] & reg_wdata_i;
    end
    if (start_acc) begin
      pending_latch_nxt[winner[3:0]] = 1'b0;
    end
    pending_latch_nxt = pending_latch_nxt | set_req;
  end

  // Register writes and latch storage
  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pending_latch_r       <= `IASQ_RST_LAT;
      source_enable_bit_r   <= 12'h000;
      level10_source_pick_r <= 1'b0;
      level15_source_pick_r <= 1'b0;
      level16_source_pick_r <= 1'b0;
    end else begin
      pending_latch_r <= pending_latch_nxt;
      if (reg_wr_i && reg_addr_i == `IASQ_ADR_ENA_LO) begin
        source_enable_bit_r[7:4] <= reg_wdata_i[7:4];
      end
      if (reg_wr_i && reg_addr_i == `IASQ_ADR_ENA_HI) begin
        source_enable_bit_r[15:8] <= reg_wdata_i;
      end
      if (reg_wr_i && reg_addr_i == `IASQ_ADR_SEL) begin
        level10_source_pick_r <= reg_wdata_i[`IASQ_SEL_L10_BIT];
        level15_source_pick_r <= reg_wdata_i[`IASQ_SEL_L15_BIT];
        level16_source_pick_r <= reg_wdata_i[`IASQ_SEL_L16_BIT];
      end
    end
  end

  // Register read port, data one cycle after the strobe
  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `IASQ_ADR_ENA_LO: reg_rdata_o <= {source_enable_bit_r[7:4], 3'h0, global_mask_enable_o};
        `IASQ_ADR_ENA_HI: reg_rdata_o <= source_enable_bit_r[15:8];
        `IASQ_ADR_LAT_LO: reg_rdata_o <= pending_latch_r[7:0];
        `IASQ_ADR_LAT_HI: reg_rdata_o <= pending_latch_r[15:8];
        `IASQ_ADR_SEL: reg_rdata_o <= {5'h00, level16_source_pick_r,
                                       level15_source_pick_r, level10_source_pick_r};
        `IASQ_ADR_SP_LO: reg_rdata_o <= stack_pointer_o[7:0];
        `IASQ_ADR_SP_HI: reg_rdata_o <= stack_pointer_o[15:8];
        `IASQ_ADR_STAT: reg_rdata_o <= {busy_o, state_r, 1'b0, accept_idx_r};
        default: reg_rdata_o <= 8'h00;
      endcase
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

  // Acceptance and return sequencer
  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_r              <= ST_IDLE;
      step_r               <= 3'h0;
      accept_idx_r         <= 4'h0;
      saved_imf_r          <= 1'b0;
      tmp_lo_r             <= 8'h00;
      tmp_hi_r             <= 8'h00;
      busy_o               <= 1'b0;
      mem_wr_o             <= 1'b0;
      mem_rd_o             <= 1'b0;
      mem_addr_o           <= 16'h0000;
      mem_wdata_o          <= 8'h00;
      pc_o                 <= 16'h0000;
      pc_load_o            <= 1'b0;
      status_word_o        <= 8'h00;
      status_load_o        <= 1'b0;
      stack_pointer_o      <= `IASQ_RST_SP;
      global_mask_enable_o <= 1'b0;
    end else begin
      mem_wr_o      <= 1'b0;
      mem_rd_o      <= 1'b0;
      pc_load_o     <= 1'b0;
      status_load_o <= 1'b0;
      if (reg_wr_i && reg_addr_i == `IASQ_ADR_ENA_LO) begin
        global_mask_enable_o <= reg_wdata_i[`IASQ_ENA_IMF_BIT];
      end
      if (reg_wr_i && reg_addr_i == `IASQ_ADR_SP_LO) begin
        stack_pointer_o[7:0] <= reg_wdata_i;
      end
      if (reg_wr_i && reg_addr_i == `IASQ_ADR_SP_HI) begin
        stack_pointer_o[15:8] <= reg_wdata_i;
      end
      if (mc_en) begin
        case (state_r)
          ST_IDLE: begin
            if (start_acc) begin
              global_mask_enable_o <= 1'b0;
              saved_imf_r  <= global_mask_enable_o;
              accept_idx_r <= winner[3:0];
              state_r      <= ST_ACC;
              step_r       <= 3'h0;
              busy_o       <= 1'b1;
            end else if (instr_last_i && (maskable_return_i || nonmaskable_return_i)) begin
              state_r <= ST_RET;
              step_r  <= 3'h0;
              busy_o  <= 1'b1;
            end
          end
          ST_ACC: begin
            step_r <= step_r + 3'h1;
            case (step_r)
              3'h0: begin
                mem_wr_o        <= 1'b1;
                mem_addr_o      <= stack_pointer_o;
                mem_wdata_o     <= {status_word_i[7:1], saved_imf_r};
                stack_pointer_o <= stack_pointer_o - 16'h0001;
              end
              3'h1: begin
                mem_wr_o        <= 1'b1;
                mem_addr_o      <= stack_pointer_o;
                mem_wdata_o     <= pc_i[15:8];
                stack_pointer_o <= stack_pointer_o - 16'h0001;
              end
              3'h2: begin
                mem_wr_o        <= 1'b1;
                mem_addr_o      <= stack_pointer_o;
                mem_wdata_o     <= pc_i[7:0];
                stack_pointer_o <= stack_pointer_o - 16'h0001;
              end
              3'h3: begin
                mem_rd_o   <= 1'b1;
                mem_addr_o <= vec_addr;
              end
              3'h4: begin
                tmp_lo_r   <= mem_rdata_i;
                mem_rd_o   <= 1'b1;
                mem_addr_o <= vec_addr + 16'h0001;
              end
              3'h5: begin
                tmp_hi_r <= mem_rdata_i;
              end
              3'h6: begin
                pc_o      <= {tmp_hi_r, tmp_lo_r};
                pc_load_o <= 1'b1;
              end
              default: begin
                state_r <= ST_IDLE;
                busy_o  <= 1'b0;
              end
            endcase
          end
          ST_RET: begin
            step_r <= step_r + 3'h1;
            case (step_r)
              3'h0: begin
                mem_rd_o   <= 1'b1;
                mem_addr_o <= stack_pointer_o + 16'h0001;
              end
              3'h1: begin
                tmp_lo_r   <= mem_rdata_i;
                mem_rd_o   <= 1'b1;
                mem_addr_o <= stack_pointer_o + 16'h0002;
              end
              3'h2: begin
                tmp_hi_r   <= mem_rdata_i;
                mem_rd_o   <= 1'b1;
                mem_addr_o <= stack_pointer_o + 16'h0003;
              end
              default: begin
                pc_o                 <= {tmp_hi_r, tmp_lo_r};
                pc_load_o            <= 1'b1;
                status_word_o        <= mem_rdata_i;
                status_load_o        <= 1'b1;
                global_mask_enable_o <= mem_rdata_i[`IASQ_PSW_IMF_BIT];
                stack_pointer_o      <= stack_pointer_o + 16'h0003;
                state_r              <= ST_IDLE;
                busy_o               <= 1'b0;
              end
            endcase
          end
          default: begin
            state_r <= ST_IDLE;
            busy_o  <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule

// ### tb/iasq_core_properties.sv
`timescale 1ns/10ps
module iasq_core_properties #(
  parameter MC_DIV = 4
) (
  input wire        clk_sys_i,
  input wire        resetn_i,
  input wire        bad_opcode_i,
  input wire        wdog_irq_i,
  input wire [7:0]  mem_wdata_o,
  input wire        fetch_valid_i,
  input wire        single_chip_i,
  input wire        mem_present_i,
  input wire [7:0]  fetch_data_o,
  input wire        busy_o,
  input wire        mem_wr_o,
  input wire [15:0] mem_addr_o,
  input wire [7:0]  status_word_o,
  input wire        status_load_o,
  input wire [15:0] stack_pointer_o,
  input wire        global_mask_enable_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!resetn_i);

  reg [7:0]  busy_cnt_r;
  reg        wrote_r;
  reg        nm_seen_r;
  reg [15:0] sp_start_r;

  // Sequence length, first push and stack pointer before each run
  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      busy_cnt_r <= 8'h00;
      wrote_r    <= 1'b0;
      nm_seen_r  <= 1'b0;
      sp_start_r <= 16'h00FF;
    end else begin
      busy_cnt_r <= busy_o ? busy_cnt_r + 8'h01 : 8'h00;
      wrote_r    <= busy_o & (wrote_r | mem_wr_o);
      nm_seen_r  <= nm_seen_r | bad_opcode_i | fetch_valid_i | wdog_irq_i;
      if (!busy_o) begin
        sp_start_r <= stack_pointer_o;
      end
    end
  end

  // Program counter bytes follow the status byte downwards
  sequence pc_pushes(logic [15:0] sp);
    ##[1:8] (mem_wr_o && mem_addr_o == sp - 16'h0001)
    ##[1:8] (mem_wr_o && mem_addr_o == sp - 16'h0002);
  endsequence

  a_push_order: assert property (mem_wr_o && !wrote_r |->
    (mem_addr_o == sp_start_r) ##0 pc_pushes(sp_start_r))
    else $error("stack pushes out of order");
  a_sp_down3: assert property ($fell(busy_o) && wrote_r |->
    stack_pointer_o == sp_start_r - 16'h0003)
    else $error("stack pointer not lowered by three");
  a_seq_length: assert property ($fell(busy_o) && wrote_r |->
    busy_cnt_r >= 7 * MC_DIV && busy_cnt_r <= 9 * MC_DIV)
    else $error("acceptance length wrong");
  a_mask_clear: assert property ($rose(busy_o) |-> (!global_mask_enable_o) [*8])
    else $error("global enable not cleared on acceptance");
  a_mask_block: assert property (mem_wr_o && !wrote_r && !nm_seen_r |->
    mem_wdata_o[0])
    else $error("maskable request taken while disabled");
  a_ret_enable: assert property (status_load_o |->
    ##[0:1] global_mask_enable_o == status_word_o[0])
    else $error("return did not restore global enable");
  a_reset_clear: assert property ($rose(resetn_i) |->
    !global_mask_enable_o && stack_pointer_o == 16'h00FF)
    else $error("reset state wrong");
  a_fetch_ff: assert property (fetch_valid_i && single_chip_i && !mem_present_i |->
    ##1 fetch_data_o == 8'hFF)
    else $error("missing memory fetch not FF");
endmodule

bind iasq_core iasq_core_properties #(.MC_DIV(MC_DIV)) u_props (
  .clk_sys_i, .resetn_i, .bad_opcode_i, .wdog_irq_i, .mem_wdata_o, .fetch_valid_i,
  .single_chip_i, .mem_present_i,
  .fetch_data_o, .busy_o, .mem_wr_o, .mem_addr_o, .status_word_o, .status_load_o,
  .stack_pointer_o, .global_mask_enable_o);

// ### tb/iasq_mem_model.sv
`timescale 1ns/10ps
module iasq_mem_model #(
  parameter MC_DIV = 4
) (
  input  wire        clk_sys_i,
  input  wire        wr_i,
  input  wire        rd_i,
  input  wire [15:0] addr_i,
  input  wire [7:0]  wdata_i,
  output reg  [7:0]  rdata_o
);
  reg [7:0] mem [0:65535];
  reg [7:0] hold_r;
  integer   i;

  // Both bytes of vector entry k hold 10h plus k
  initial begin
    for (i = 0; i < 16; i = i + 1) begin
      mem[16'hFFFE - 2 * i] = 8'h10 + i;
      mem[16'hFFFF - 2 * i] = 8'h10 + i;
    end
    rdata_o = 8'h00;
    hold_r  = 8'h00;
  end

  // Read byte good for one machine cycle, then the line toggles
  always @(posedge clk_sys_i) begin
    if (wr_i) begin
      mem[addr_i] <= wdata_i;
    end
    if (rd_i) begin
      rdata_o <= mem[addr_i];
      hold_r  <= MC_DIV[7:0];
    end else if (hold_r != 8'h00) begin
      hold_r <= hold_r - 8'h01;
    end else begin
      rdata_o <= ~rdata_o;
    end
  end
endmodule

// ### tb/interrupt_accept_sequencer_test.sv
`timescale 1ns/10ps
module interrupt_accept_sequencer_test;
  reg         clk_sys_i, resetn_i, reg_wr_i, reg_rd_i, instr_last_i, mret, wdog;
  reg         bad_opcode_i, fetch_valid_i, single_chip_i, mem_present_i, ok_r;
  reg  [7:0]  reg_addr_i, reg_wdata_i;
  reg  [15:4] irq_i;
  reg  [5:0]  shr;
  reg  [15:0] fetch_addr_i, last_pc, ret_pc;
  wire [7:0]  reg_rdata_o, mem_rdata_i, fetch_data_o, mem_wdata_o, status_word_o;
  wire [15:0] mem_addr_o, pc_o, stack_pointer_o;
  wire        mc_tick_o, busy_o, mem_wr_o, mem_rd_o, pc_load_o, status_load_o;
  wire        global_mask_enable_o;
  integer     err_count, n_tests, cyc;

  iasq_core #(.MC_DIV(4)) DUT (
    .clk_sys_i, .resetn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .irq_i, .serial_receive_irq_i(shr[0]), .sync_serial_irq_i(shr[1]),
    .ext_input_three_irq_i(shr[2]), .timer_three_irq_i(shr[3]),
    .ext_input_five_irq_i(shr[4]), .timer_five_irq_i(shr[5]), .wdog_irq_i(wdog),
    .instr_last_i, .maskable_return_i(mret), .nonmaskable_return_i(1'b0), .bad_opcode_i,
    .fetch_valid_i, .fetch_addr_i, .single_chip_i, .mem_present_i, .mem_rdata_i,
    .pc_i(16'hABCD), .status_word_i(8'h5A), .mc_tick_o, .fetch_data_o, .busy_o,
    .mem_wr_o, .mem_rd_o, .mem_addr_o, .mem_wdata_o, .pc_o, .pc_load_o, .status_word_o,
    .status_load_o, .stack_pointer_o, .global_mask_enable_o);

  iasq_mem_model #(.MC_DIV(4)) u_mem (.clk_sys_i, .wr_i(mem_wr_o), .rd_i(mem_rd_o),
    .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i));

  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end

  // Remember loaded program counters; cut a hung run short
  always @(posedge clk_sys_i) begin
    if (pc_load_o) last_pc <= pc_o;
    if (status_load_o) ret_pc <= pc_o;
    cyc = cyc + 1;
    if (cyc == 20000) begin
      err_count = err_count + 1;
      stop_test;
    end
  end

  task stop_test;
    begin
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask

  task chk(input [15:0] got, input [15:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask

  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge clk_sys_i);
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      reg_wr_i    <= 1'b1;
      @(posedge clk_sys_i);
      reg_wr_i <= 1'b0;
    end
  endtask

  task rdc(input [7:0] a, input [7:0] exp);
    begin
      @(posedge clk_sys_i);
      reg_addr_i <= a;
      reg_rd_i   <= 1'b1;
      @(posedge clk_sys_i);
      reg_rd_i <= 1'b0;
      #1 chk({8'h00, reg_rdata_o}, {8'h00, exp});
    end
  endtask

  // Bounded wait on busy level (sel 0) or a loaded program counter (sel 1)
  task wt(input sel, input [15:0] e, input integer lim);
    integer i;
    begin
      ok_r = 1'b0;
      for (i = 0; i < lim && !ok_r; i = i + 1) begin
        @(posedge clk_sys_i);
        #1 ok_r = sel ? (last_pc === e) : (busy_o === e[0]);
      end
    end
  endtask

  task t_reset_vals;
    integer a;
    for (a = 0; a < 9; a = a + 1) rdc(a[7:0], (a == 5) ? 8'hFF : 8'h00);
  endtask

  task t_shared;
    integer k, s;
    reg [7:0] pos;
    for (k = 0; k < 3; k = k + 1) for (s = 0; s < 2; s = s + 1) begin
      pos = (k == 0) ? 8'h02 : (k == 1) ? 8'h40 : 8'h80;
      wr(8'h04, s ? (8'h01 << k) : 8'h00);
      rdc(8'h04, s ? (8'h01 << k) : 8'h00);
      @(posedge clk_sys_i) shr <= 6'h01 << (2 * k + 1 - s);
      @(posedge clk_sys_i) shr <= 6'h00;
      rdc(8'h03, 8'h00);
      @(posedge clk_sys_i) shr <= 6'h01 << (2 * k + s);
      @(posedge clk_sys_i) shr <= 6'h00;
      rdc(8'h03, pos);
      wr(8'h03, 8'h00);
      rdc(8'h03, 8'h00);
    end
  endtask

  task t_accept;
    begin
      wr(8'h00, 8'h30);
      @(posedge clk_sys_i) irq_i <= 12'h003;
      @(posedge clk_sys_i) irq_i <= 12'h000;
      rdc(8'h02, 8'h30);
      wr(8'h00, 8'h31);
      wt(1'b0, 16'h0001, 38); chk(ok_r, 1'b1);
      wt(1'b1, 16'h1414, 60); chk(ok_r, 1'b1);
      wt(1'b0, 16'h0000, 40);
      rdc(8'h00, 8'h30);
      rdc(8'h02, 8'h20);
      rdc(8'h05, 8'hFC);
      chk(u_mem.mem[16'h00FF], 16'h005B);
      chk({u_mem.mem[16'h00FE], u_mem.mem[16'h00FD]}, 16'hABCD);
      wt(1'b0, 16'h0001, 40); chk(ok_r, 1'b0);
    end
  endtask

  // Maskable return issued across exactly one machine-cycle enable
  task t_return;
    integer i;
    begin
      for (i = 0; i < 8 && mc_tick_o !== 1'b1; i = i + 1) begin
        @(posedge clk_sys_i);
        #1;
      end
      @(posedge clk_sys_i) mret <= 1'b1;
      repeat (4) @(posedge clk_sys_i);
      mret <= 1'b0;
      wt(1'b1, 16'h1515, 80); chk(ok_r, 1'b1);
      chk(ret_pc, 16'hABCD);
      wt(1'b0, 16'h0000, 40);
      rdc(8'h05, 8'hFC);
    end
  endtask

  task t_traps;
    integer k;
    for (k = 0; k < 3; k = k + 1) begin
      @(posedge clk_sys_i);
      bad_opcode_i  <= (k == 0);
      fetch_valid_i <= (k == 1);
      wdog          <= (k == 2);
      fetch_addr_i  <= 16'h0F80;
      @(posedge clk_sys_i);
      bad_opcode_i  <= 1'b0;
      fetch_valid_i <= 1'b0;
      wdog          <= 1'b0;
      wt(1'b1, (k == 0) ? 16'h1111 : (k == 1) ? 16'h1212 : 16'h1313, 80);
      chk(ok_r, 1'b1);
      wt(1'b0, 16'h0000, 40);
    end
  endtask

  task t_nomem;
    begin
      @(posedge clk_sys_i);
      single_chip_i <= 1'b1;
      fetch_addr_i  <= 16'h8000;
      fetch_valid_i <= 1'b1;
      @(posedge clk_sys_i);
      fetch_valid_i <= 1'b0;
      #1 chk({8'h00, fetch_data_o}, 16'h00FF);
      wt(1'b1, 16'h1010, 80);
      chk(ok_r, 1'b1);
    end
  endtask

  initial begin
    {resetn_i, reg_wr_i, reg_rd_i, mret, bad_opcode_i, fetch_valid_i, wdog} = 7'h00;
    {single_chip_i, mem_present_i, instr_last_i} = 3'b001;
    {reg_addr_i, reg_wdata_i, irq_i, shr} = 34'h0;
    fetch_addr_i = 16'h8000;
    {last_pc, ret_pc} = 32'h0;
    {err_count, n_tests, cyc} = 96'h0;
    repeat (2) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    t_reset_vals;
    t_shared;
    t_accept;
    t_return;
    t_traps;
    t_nomem;
    stop_test;
  end
endmodule
